/* File: src/nand_irq_defines.svh */
`ifndef NAND_IRQ_DEFINES_SVH
`define NAND_IRQ_DEFINES_SVH

// register byte addresses
`define ADDR_WP_LOW 32'h200B_8028
`define ADDR_WP_HIGH 32'h200B_802C
`define ADDR_CONFIG 32'h200B_8030
`define ADDR_TIMING 32'h200B_8034
`define ADDR_MASK 32'h200B_8038
`define ADDR_STATUS 32'h200B_803C

// event positions, shared by status and mask
`define BIT_WP_FAULT 0
`define BIT_ECC_RDY 1
`define BIT_DEC_ERR 2
`define BIT_DEC_FAIL 3
`define BIT_CTRL_RDY 4
`define BIT_NAND_RDY 5
`define EVENT_W 6

// configuration and timing fields
`define CFG_WP_EN 3
`define CFG_W 4
`define TIME_W 26
`define BUSY_MSB 23
`define BUSY_LSB 19
`define WP_ADDR_W 24

// reset values
`define MASK_RESET 6'h00
`define STATUS_RESET 6'h00
`define CNT_ONE 5'h01
`define CNT_ZERO 5'h00

// flash commands
`define CMD_SERIAL_IN 8'h80
`define CMD_ERASE 8'h60
`define CMD_PROG_A 8'h10
`define CMD_PROG_B 8'h11
`define CMD_PROG_C 8'h15

// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: src/nand_irq_pkg.sv */
package nand_irq_pkg;
  typedef logic [5:0] event_vec_t;
  typedef enum logic [1:0] {
    PROT_IDLE = 2'b00,
    PROT_ARMED = 2'b01,
    PROT_CAPTURED = 2'b10
  } prot_state_t;
endpackage

/* File: src/nand_ecc_irq_logic.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nand_irq_defines.svh"

// Summary of operation
// - mask bit 3 enables the uncorrectable decode failure interrupt.
// - decode failure event when decoder errors exceed its correction capability.
// - decode error event, mask bit 2, on any decoder error found.
// - encode ready follows encode start, 518 byte writes and encode completion.
// - decode ready follows decode start, 518 or 528 byte reads and completion.
// - protected target aborts write or erase and raises fault, mask bit 0.
// - fault check fires on command 0x60, 0x10, 0x11 or 0x15.
// - fault only with protection enabled and captured address inside range.
// - nand ready bit 5 on busy to ready edge, after busy delay.
// - controller ready bit 4 on parity read/write or auto decode/encode done.
// - each status bit stays set after its event.
// - reading the status register clears all bits except any whose event lands in the read cycle.
// - status records events regardless of mask.
// - interrupt is OR of status bits ANDed with mask bits.
// - status bits 7 and 6 read as zero.
// - all sources masked after reset; set mask bit enables.
// - status bits 3..0 match mask layout positions.
module nand_ecc_irq_logic (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic [31:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [31:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic FLASH_RDY_I,
  input wire logic CTRL_DONE_I,
  input wire logic ECC_ENC_DONE_I,
  input wire logic ECC_DEC_DONE_I,
  input wire logic DEC_ERR_FOUND_I,
  input wire logic DEC_UNCORR_I,
  input wire logic CMD_VALID_I,
  input wire logic [7:0] CMD_I,
  input wire logic ADDR_VALID_I,
  input wire logic [23:0] ADDR_I,
  output logic WP_ABORT_O,
  output logic IRQ_O
);

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic awready_q, awready_d, wready_q, wready_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic rd_stat_q;
  logic [`WP_ADDR_W-1:0] wp_lo_q, wp_hi_q;
  logic [`CFG_W-1:0] cfg_q;
  logic [`TIME_W-1:0] time_q;
  nand_irq_pkg::event_vec_t mask_q, status_q, status_d, ev;
  logic irq_q, abort_q;
  logic rdy_prev_q, cnt_run_q;
  logic [4:0] busy_cnt_q;
  logic [`WP_ADDR_W-1:0] cap_addr_q;
  nand_irq_pkg::prot_state_t prot_q, prot_d;

  // write channel handshakes; address and data are taken in either order
  wire aw_take = S_AXI_AWVALID_I & awready_q;
  wire w_take = S_AXI_WVALID_I & wready_q;
  wire wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  wire b_done = bvalid_q & S_AXI_BREADY_I;
  assign aw_held_d = (aw_held_q & ~wr_fire) | aw_take;
  assign w_held_d = (w_held_q & ~wr_fire) | w_take;
  assign awready_d = ~aw_held_d;
  assign wready_d = ~w_held_d;
  assign bvalid_d = wr_fire | (bvalid_q & ~b_done);

  // write decode
  wire wr_lo = wr_fire & (awaddr_q == `ADDR_WP_LOW);
  wire wr_hi = wr_fire & (awaddr_q == `ADDR_WP_HIGH);
  wire wr_cfg = wr_fire & (awaddr_q == `ADDR_CONFIG);
  wire wr_time = wr_fire & (awaddr_q == `ADDR_TIMING);
  wire wr_mask = wr_fire & (awaddr_q == `ADDR_MASK);
  wire wr_stat = wr_fire & (awaddr_q == `ADDR_STATUS);
  wire wr_hit = wr_lo | wr_hi | wr_cfg | wr_time | wr_mask | wr_stat;
  // partial writes keep the untouched byte lanes of the old value
  wire [31:0] lo_new = merge_bytes(32'(wp_lo_q), wdata_q, wstrb_q);
  wire [31:0] hi_new = merge_bytes(32'(wp_hi_q), wdata_q, wstrb_q);
  wire [31:0] cfg_new = merge_bytes(32'(cfg_q), wdata_q, wstrb_q);
  wire [31:0] time_new = merge_bytes(32'(time_q), wdata_q, wstrb_q);
  wire [31:0] mask_new = merge_bytes(32'(mask_q), wdata_q, wstrb_q);

  // read channel; one read outstanding, arready drops until the data is taken
  wire rd_take = S_AXI_ARVALID_I & arready_q;
  wire r_done = rvalid_q & S_AXI_RREADY_I;
  assign rvalid_d = rd_take | (rvalid_q & ~r_done);
  assign arready_d = rd_take ? 1'b0 : (r_done ? 1'b1 : arready_q);
  // read decode looks at the live address, so it only counts in the take cycle
  wire rd_is_stat = S_AXI_ARADDR_I == `ADDR_STATUS;
  wire rd_is_mask = S_AXI_ARADDR_I == `ADDR_MASK;
  wire rd_is_cfg = S_AXI_ARADDR_I == `ADDR_CONFIG;
  wire rd_is_time = S_AXI_ARADDR_I == `ADDR_TIMING;
  wire rd_is_lo = S_AXI_ARADDR_I == `ADDR_WP_LOW;
  wire rd_is_hi = S_AXI_ARADDR_I == `ADDR_WP_HIGH;
  wire rd_hit = rd_is_stat | rd_is_mask | rd_is_cfg | rd_is_time | rd_is_lo | rd_is_hi;
  // upper status bits are never stored, so they read back as zero
  wire [31:0] rd_word = rd_is_stat ? 32'(status_q) :
                        rd_is_mask ? 32'(mask_q) :
                        rd_is_cfg ? 32'(cfg_q) :
                        rd_is_time ? 32'(time_q) :
                        rd_is_lo ? 32'(wp_lo_q) :
                        rd_is_hi ? 32'(wp_hi_q) : 32'h0000_0000;
  wire rd_status_clr = rd_take & rd_is_stat;

  // bus-side flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
    end
  end

  // bus payload flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
      rd_stat_q <= 1'b0;
    end else begin
      if (aw_take) awaddr_q <= S_AXI_AWADDR_I;
      if (w_take) wdata_q <= S_AXI_WDATA_I;
      if (w_take) wstrb_q <= S_AXI_WSTRB_I;
      if (wr_fire) bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (rd_take) rdata_q <= rd_word;
      if (rd_take) rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      if (rd_take) rd_stat_q <= rd_is_stat;
    end
  end

  // software registers; status is read-only, a write to it is accepted and dropped
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      wp_lo_q <= 24'h00_0000;
      wp_hi_q <= 24'h00_0000;
      cfg_q <= 4'h0;
      time_q <= 26'h000_0000;
      mask_q <= `MASK_RESET;
    end else begin
      if (wr_lo) wp_lo_q <= lo_new[`WP_ADDR_W-1:0];
      if (wr_hi) wp_hi_q <= hi_new[`WP_ADDR_W-1:0];
      if (wr_cfg) cfg_q <= cfg_new[`CFG_W-1:0];
      if (wr_time) time_q <= time_new[`TIME_W-1:0];
      if (wr_mask) mask_q <= mask_new[`EVENT_W-1:0];
    end
  end

  // nand ready: rising edge of ready/busy, then the programmed busy delay
  // a delay of zero sets the bit straight on the edge, otherwise the counter runs it out
  wire [4:0] busy_dly = time_q[`BUSY_MSB:`BUSY_LSB];
  wire rdy_rise = FLASH_RDY_I & ~rdy_prev_q;
  wire cnt_end = cnt_run_q & (busy_cnt_q == `CNT_ONE);
  wire nand_ev = (rdy_rise & (busy_dly == `CNT_ZERO)) | cnt_end;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdy_prev_q <= 1'b1;
      cnt_run_q <= 1'b0;
      busy_cnt_q <= `CNT_ZERO;
    end else begin
      rdy_prev_q <= FLASH_RDY_I;
      if (rdy_rise && busy_dly != `CNT_ZERO) begin
        cnt_run_q <= 1'b1;
        busy_cnt_q <= busy_dly;
      end else if (cnt_end) begin
        cnt_run_q <= 1'b0;
      end else if (cnt_run_q) begin
        busy_cnt_q <= busy_cnt_q - `CNT_ONE;
      end
    end
  end

  // write protection: capture the address after serial input or erase, check on start
  wire is_trig = CMD_VALID_I & ((CMD_I == `CMD_PROG_A) | (CMD_I == `CMD_PROG_B) |
                                (CMD_I == `CMD_PROG_C) | (CMD_I == `CMD_ERASE));
  wire is_arm = CMD_VALID_I & ((CMD_I == `CMD_SERIAL_IN) | (CMD_I == `CMD_ERASE));
  wire in_range = (cap_addr_q >= wp_lo_q) & (cap_addr_q <= wp_hi_q);
  wire wp_fault = (prot_q == nand_irq_pkg::PROT_CAPTURED) & is_trig & cfg_q[`CFG_WP_EN] & in_range;

  // an erase command both ends a sequence and arms the next capture
  always_comb begin
    prot_d = prot_q;
    case (prot_q)
      nand_irq_pkg::PROT_IDLE: begin
        if (is_arm) prot_d = nand_irq_pkg::PROT_ARMED;
      end
      nand_irq_pkg::PROT_ARMED: begin
        if (ADDR_VALID_I) prot_d = nand_irq_pkg::PROT_CAPTURED;
      end
      nand_irq_pkg::PROT_CAPTURED: begin
        if (is_arm) prot_d = nand_irq_pkg::PROT_ARMED;
        else if (is_trig) prot_d = nand_irq_pkg::PROT_IDLE;
      end
      default: prot_d = nand_irq_pkg::PROT_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      prot_q <= nand_irq_pkg::PROT_IDLE;
      cap_addr_q <= 24'h00_0000;
      abort_q <= 1'b0;
    end else begin
      prot_q <= prot_d;
      if (ADDR_VALID_I && prot_q != nand_irq_pkg::PROT_IDLE) cap_addr_q <= ADDR_I;
      abort_q <= wp_fault;
    end
  end

  // event vector, one bit per source in the shared layout
  assign ev[`BIT_WP_FAULT] = wp_fault;
  assign ev[`BIT_ECC_RDY] = ECC_ENC_DONE_I | ECC_DEC_DONE_I;
  assign ev[`BIT_DEC_ERR] = ECC_DEC_DONE_I & DEC_ERR_FOUND_I;
  assign ev[`BIT_DEC_FAIL] = ECC_DEC_DONE_I & DEC_UNCORR_I;
  assign ev[`BIT_CTRL_RDY] = CTRL_DONE_I;
  assign ev[`BIT_NAND_RDY] = nand_ev;

  // set wins over the read clear so a coincident event is kept
  assign status_d = (rd_status_clr ? `STATUS_RESET : status_q) | ev;

  // status and interrupt; irq follows the next status so it lands with it
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      status_q <= `STATUS_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  // every pin is a flop output, so nothing combinational reaches the host
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign WP_ABORT_O = abort_q;
  assign IRQ_O = irq_q;

  // checks run on the bus clock and sleep while reset is held
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  // a read and an event in one cycle: the event must survive the clear
  clear_keeps_event_a: assert property ((rd_status_clr && ev != 6'h00) |=>
    ((status_q & $past(ev)) == $past(ev) && IRQ_O == |($past(ev) & $past(mask_q))))
    else $error("event lost on status read");
  // nothing but a status read may drop a bit
  sticky_bits_a: assert property (!rd_status_clr |=> ((status_q & $past(status_q)) == $past(status_q)))
    else $error("status bit dropped without read");
  read_clears_a: assert property ((rd_status_clr && ev == 6'h00) |=> status_q == 6'h00 ##1
    (!S_AXI_RVALID_O || rd_stat_q))
    else $error("status not cleared by read");
  resv_zero_a: assert property ((S_AXI_RVALID_O && rd_stat_q) |-> S_AXI_RDATA_O[31:6] == 26'h000_0000)
    else $error("reserved status bits nonzero");
  irq_gate_a: assert property ((status_q & mask_q) != 6'h00 && !rd_status_clr |=> IRQ_O)
    else $error("unmasked status did not raise interrupt");
  masked_quiet_a: assert property (mask_q == 6'h00 && $past(mask_q) == 6'h00 |-> !IRQ_O)
    else $error("interrupt with all sources masked");
  // an uncorrectable decode that also flags an error found sets fail, error and decode ready together
  dec_flags_a: assert property (ECC_DEC_DONE_I && DEC_UNCORR_I && DEC_ERR_FOUND_I |=>
    status_q[`BIT_DEC_FAIL] && status_q[`BIT_DEC_ERR] && status_q[`BIT_ECC_RDY])
    else $error("decode flags not recorded");
  dec_err_a: assert property (ECC_DEC_DONE_I && DEC_ERR_FOUND_I |=> status_q[`BIT_DEC_ERR])
    else $error("decode error not recorded");
  // a fault aborts the flash operation and records itself in one step
  fault_abort_a: assert property (wp_fault |=> WP_ABORT_O && status_q[`BIT_WP_FAULT])
    else $error("protection fault without abort");
  no_fault_off_a: assert property (!cfg_q[`CFG_WP_EN] |=> !WP_ABORT_O)
    else $error("fault with protection disabled");
  // with a delay of five the event must wait out four quiet cycles first
  nand_delay_a: assert property ((rdy_rise && busy_dly == 5'h05) |=> !nand_ev [*4] ##1 nand_ev ##1
    status_q[`BIT_NAND_RDY])
    else $error("nand ready not after busy delay");
  ctrl_rdy_a: assert property (CTRL_DONE_I |=> status_q[`BIT_CTRL_RDY])
    else $error("controller ready not recorded");

  // the shared ready bit takes both the encoder and the decoder
  enc_ready_a: assert property (ECC_ENC_DONE_I |=> status_q[`BIT_ECC_RDY])
    else $error("encode ready not recorded");
  dec_ready_a: assert property (ECC_DEC_DONE_I |=> status_q[`BIT_ECC_RDY])
    else $error("decode ready not recorded");

  // only a confirm command may run the protection check
  trig_only_a: assert property (!is_trig |=> !WP_ABORT_O)
    else $error("abort without confirm command");
  // outside the window never faults; both bounds count as inside
  range_only_a: assert property ((is_trig && !in_range) |=> !WP_ABORT_O)
    else $error("abort outside protected range");
  // the check ends the sequence, so a second abort needs a new address phase
  abort_pulse_a: assert property (WP_ABORT_O |=> !WP_ABORT_O)
    else $error("abort held longer than one cycle");

  // events land whatever the mask says
  events_kept_a: assert property (ev != 6'h00 |=> (status_q & $past(ev)) == $past(ev))
    else $error("event not recorded in status");
  // no bit rises without its own event
  set_by_event_a: assert property (ev == 6'h00 |=> (status_q & ~$past(status_q)) == 6'h00)
    else $error("status bit set without event");
  // a clean read drops the line in the same cycle the bits go
  clear_drops_irq_a: assert property ((rd_status_clr && ev == 6'h00) |=> !IRQ_O)
    else $error("interrupt held after status read");

  // bus answers: response one cycle after the write fires, read data one after the take
  write_answer_a: assert property (wr_fire |=> S_AXI_BVALID_O)
    else $error("write response late");
  read_answer_a: assert property (rd_take |=> S_AXI_RVALID_O)
    else $error("read data late");

  irq_seen_c: cover property (!IRQ_O ##1 IRQ_O);
  read_clear_c: cover property (rd_status_clr && status_q != 6'h00);
  fault_seen_c: cover property (wp_fault);
  // delayed flash ready and an event meeting a status read
  nand_ready_c: cover property (nand_ev);
  collide_c: cover property (rd_status_clr && ev != 6'h00);

endmodule // nand_ecc_irq_logic
`default_nettype wire

/* File: dv/nand_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// cpu side bus master; one write and one read at most, never assumes a latency
module nand_host_model (
  input wire logic clk_i,
  output logic [31:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [31:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // idle bus at time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= 4'hF;
    awvalid_o <= 1'b1;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (awvalid_o || wvalid_o || !bvalid_i) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'b0;
      if (wvalid_o && wready_i) wvalid_o <= 1'b0;
    end
    r = bresp_i;
    bready_o <= 1'b0;
  endtask

  // status read is how the host learns which source fired
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (arvalid_o || !rvalid_i) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'b0;
    end
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule // nand_host_model
`default_nettype wire

/* File: dv/tb_nand_ecc_irq_logic.sv */
`timescale 1ns/10ps
`default_nettype none
`include "nand_irq_defines.svh"
module tb_nand_ecc_irq_logic;
  logic clk, rst_b, rdy, ctrl_done, enc_done, dec_done, err_found, uncorr, cmd_valid, addr_valid;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, abort, irq;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int aborts = 0;

  nand_ecc_irq_logic i_nand_ecc_irq_logic (.CLK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb),
    .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .FLASH_RDY_I(rdy), .CTRL_DONE_I(ctrl_done), .ECC_ENC_DONE_I(enc_done), .ECC_DEC_DONE_I(dec_done),
    .DEC_ERR_FOUND_I(err_found), .DEC_UNCORR_I(uncorr), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .ADDR_VALID_I(addr_valid), .ADDR_I(addr), .WP_ABORT_O(abort), .IRQ_O(irq));

  nand_host_model i_nand_host_model (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  // clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // a hung handshake must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    aborts <= aborts + int'(abort === 1'b1);
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end

  // event sources; done pulses stand for finished 518/528 byte cycles
  task automatic fire(input int idx);
    @(posedge clk);
    case (idx)
      1: enc_done <= 1'b1;
      2: {dec_done, err_found} <= 2'b11;
      3: {dec_done, err_found, uncorr} <= 3'b111;
      4: ctrl_done <= 1'b1;
      default: dec_done <= 1'b1;
    endcase
    @(posedge clk);
    {enc_done, dec_done, err_found, uncorr, ctrl_done} <= '0;
  endtask

  task automatic flash_op(input logic [7:0] c, input logic [23:0] a, input logic is_addr);
    @(posedge clk);
    cmd <= c;
    addr <= a;
    cmd_valid <= !is_addr;
    addr_valid <= is_addr;
    @(posedge clk);
    {cmd_valid, addr_valid} <= 2'b00;
  endtask

  // reset values, unmapped place, wide write trimmed to register width
  task automatic t_reset();
    chk("irq", irq, 0);
    i_nand_host_model.rd(`ADDR_MASK, rd_v, resp);
    chk("mask", rd_v, 0);
    chk("mask rresp", resp, `RESP_OKAY);
    i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
    chk("status", rd_v, 0);
    i_nand_host_model.rd(32'h200B_8040, rd_v, resp);
    chk("unmapped rdata", rd_v, 32'h0000_0000);
    chk("unmapped rresp", resp, `RESP_SLVERR);
    i_nand_host_model.wr(32'h200B_8040, 32'hFFFF_FFFF, resp);
    chk("unmapped bresp", resp, `RESP_SLVERR);
    i_nand_host_model.wr(`ADDR_MASK, 32'hFFFF_FFFF, resp);
    chk("mask bresp", resp, `RESP_OKAY);
    i_nand_host_model.rd(`ADDR_MASK, rd_v, resp);
    chk("mask wide", rd_v, 32'h0000_003F);
    i_nand_host_model.wr(`ADDR_MASK, 0, resp);
  endtask

  // encode, decode error, decode failure, controller ready and plain decode in turn: irq with its own enable, none with the others, status kept and cleared on read
  task automatic t_sources();
    logic [5:0] exp_st [1:5] = '{6'h02, 6'h06, 6'h0E, 6'h10, 6'h02};
    logic [5:0] en [1:5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h02};
    for (int i = 1; i <= 5; i++) begin
      i_nand_host_model.wr(`ADDR_MASK, {26'h0, en[i]}, resp);
      fire(i);
      repeat (2) @(posedge clk);
      chk("irq on", irq, 1);
      i_nand_host_model.wr(`ADDR_MASK, {26'h0, ~exp_st[i]}, resp);
      repeat (2) @(posedge clk);
      chk("irq masked", irq, 0);
      i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
      chk("status", rd_v, {26'h0, exp_st[i]});
      i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
      chk("status cleared", rd_v, 0);
    end
  endtask

  // busy to ready edge, bit held back by the busy delay field
  task automatic t_nand_ready();
    i_nand_host_model.wr(`ADDR_TIMING, 32'h0028_0000, resp);
    i_nand_host_model.wr(`ADDR_MASK, 32'h0000_0020, resp);
    @(posedge clk);
    rdy <= 1'b0;
    repeat (3) @(posedge clk);
    rdy <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("ready early", irq, 0);
    repeat (3) @(posedge clk);
    #1 chk("ready late", irq, 1);
    i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
    chk("ready status", rd_v, 32'h0000_0020);
  endtask

  // protection check: bounds inclusive, every confirm command, enable off
  task automatic t_protect();
    logic [7:0] arm [7] = '{8'h80, 8'h80, 8'h80, 8'h60, 8'h80, 8'h80, 8'h80};
    logic [23:0] adr [7] = '{24'h00_1800, 24'h00_2000, 24'h00_1000, 24'h00_1800, 24'h00_2001, 24'h00_0FFF, 24'h00_1800};
    logic [7:0] conf [7] = '{8'h10, 8'h11, 8'h15, 8'h60, 8'h10, 8'h10, 8'h10};
    logic [6:0] hit = 7'b0001111;
    int base;
    i_nand_host_model.wr(`ADDR_WP_LOW, 32'h0000_1000, resp);
    i_nand_host_model.wr(`ADDR_WP_HIGH, 32'h0000_2000, resp);
    for (int i = 0; i < 7; i++) begin
      i_nand_host_model.wr(`ADDR_CONFIG, (i == 6) ? 32'h0 : 32'h8, resp);
      i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
      base = aborts;
      flash_op(arm[i], 0, 1'b0);
      flash_op(0, adr[i], 1'b1);
      flash_op(conf[i], 0, 1'b0);
      repeat (4) @(posedge clk);
      chk("abort count", aborts - base, hit[i]);
      i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
      chk("fault bit", rd_v, hit[i]);
    end
  endtask

  // event in the very cycle the status read is taken
  task automatic t_collide();
    fork
      i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
      fire(4);
    join
    chk("collide read", rd_v, 32'h0000_0000);
    i_nand_host_model.wr(`ADDR_STATUS, 32'h0000_003F, resp);
    chk("status write bresp", resp, `RESP_OKAY);
    i_nand_host_model.rd(`ADDR_STATUS, rd_v, resp);
    chk("kept event", rd_v, 32'h0000_0010);
  endtask

  initial begin
    {rst_b, ctrl_done, enc_done, dec_done, err_found, uncorr, cmd_valid, addr_valid} = '0;
    rdy = 1'b1;
    cmd = '0;
    addr = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_sources();
    t_nand_ready();
    t_protect();
    t_collide();
    complete_run();
  end
endmodule // tb_nand_ecc_irq_logic
`default_nettype wire
